// ---- bsm_regs.vh ----
/*
 * Constants for the buck switch-mode control block: register offsets,
 * field positions, reset values and timing figures.
 * Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
 */
`ifndef BSM_REGS_VH
`define BSM_REGS_VH

// ==========================================================
// Register byte offsets
`define BSM_OFF_CTRL 8'h00
`define BSM_OFF_OFFTIME 8'h04
`define BSM_OFF_STATUS 8'h08
`define BSM_OFF_SSCOUNT 8'h0c

// ==========================================================
// Control register fields and reset values
`define BSM_CTRL_ENABLE_BIT 0
`define BSM_CTRL_FPWM_BIT 1
`define BSM_CTRL_ENABLE_RST 1'h1
`define BSM_CTRL_FPWM_RST 1'h0
`define BSM_OFFTIME_RST 16'h0032

// ==========================================================
// Timing figures
`define BSM_CLK_MHZ 100
`define BSM_BLANK_LONG_US 150
`define BSM_BLANK_MID_US 100
`define BSM_BLANK_SHORT_US 50
`define BSM_BLANK_LONG_CYC 16'h3a98
`define BSM_BLANK_MID_CYC 16'h2710
`define BSM_BLANK_SHORT_CYC 16'h1388
`define BSM_SS_END_CNT 10'h300
`define BSM_EXT_SHIFT 2

// ==========================================================
// Blanking select codes from the four-level detector
`define BSM_BSEL_SUPPLY 2'h3
`define BSM_BSEL_OPEN 2'h2
`define BSM_BSEL_REF 2'h1
`define BSM_BSEL_GND 2'h0

`endif

// ---- bsm_sync.v ----
/*
 * Two-stage synchroniser for a bundle of asynchronous levels.
 * Assumes each bit is a slow level; bits are not coherent as a word.
 */
`timescale 1ns/1ps
module bsm_sync #(
  parameter W = 1
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ---- bsm_cycle_timer.v ----
/*
 * Down-counting cycle timer; busy while the count is non-zero.
 * Assumes load is a one-cycle request; a load restarts a running count.
 */
`timescale 1ns/1ps
module bsm_cycle_timer #(
  parameter W = 16
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire load,
  input wire [W-1:0] load_val,
  output wire busy
);

  reg [W-1:0] cnt_ff;
  reg [W-1:0] nxt_cnt;

  always @*
  begin
    nxt_cnt = cnt_ff;
    if (load)
      nxt_cnt = load_val;
    else if (cnt_ff != {W{1'b0}})
      nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      cnt_ff <= {W{1'b0}};
    else
      cnt_ff <= nxt_cnt;
  end

  assign busy = (cnt_ff != {W{1'b0}});

endmodule

// ---- bsm_ctrl.v ----
/*
 * Buck switch-mode control: mode selection, switch sequencing,
 * soft-start, extended off-time, power-good and open-drain gates.
 * Assumes analog comparators deliver asynchronous levels and that
 * the power stage adds its own dead time between the two switches.
 */
`timescale 1ns/1ps
`include "bsm_regs.vh"
module bsm_ctrl #(
  parameter [15:0] BLANK_LONG_CYC = `BSM_BLANK_LONG_CYC,
  parameter [15:0] BLANK_MID_CYC = `BSM_BLANK_MID_CYC,
  parameter [15:0] BLANK_SHORT_CYC = `BSM_BLANK_SHORT_CYC
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire shutdown_n,
  input wire pwm_force_in,
  input wire voltage_sel_in,
  input wire [1:0] blanking_select_in,
  input wire fb_below_ref_in,
  input wire fb_under_window_in,
  input wire fb_over_window_in,
  input wire fb_below_third_in,
  input wire cur_limit_in,
  input wire cur_light_in,
  input wire cur_zero_in,
  input wire load_light_in,
  input wire switch_node,
  output reg high_side_on_ff,
  output reg low_side_on_ff,
  output reg [1:0] ilim_level_ff,
  input wire power_ok_out_i,
  output reg power_ok_out_o,
  output reg power_ok_out_oe,
  input wire direct_drain_out_i,
  output reg direct_drain_out_o,
  output reg direct_drain_out_oe,
  input wire inv_drain_out_i,
  output reg inv_drain_out_o,
  output reg inv_drain_out_oe
);

  // ==========================================================
  // States
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_HS = 5'h02;
  localparam [4:0] ST_LS = 5'h04;
  localparam [4:0] ST_SKIP_LS = 5'h08;
  localparam [4:0] ST_SKIP_WAIT = 5'h10;

  // ==========================================================
  // Functions
  function [15:0] blank_cycles;
    input [1:0] code;
    begin
      case (code)
        `BSM_BSEL_SUPPLY: blank_cycles = BLANK_LONG_CYC;
        `BSM_BSEL_OPEN: blank_cycles = BLANK_MID_CYC;
        `BSM_BSEL_REF: blank_cycles = BLANK_SHORT_CYC;
        default: blank_cycles = BLANK_MID_CYC;
      endcase
    end
  endfunction

  function blank_enabled;
    input [1:0] code;
    begin
      blank_enabled = (code != `BSM_BSEL_GND);
    end
  endfunction

  // ==========================================================
  // Input synchronisation
  wire [18:0] raw_in;
  wire [18:0] syn;
  wire sd_n_s;
  wire fpwm_s;
  wire vsel_s;
  wire [1:0] bsel_s;
  wire fb_low_s;
  wire win_under_s;
  wire win_over_s;
  wire fb_third_s;
  wire ilim_s;
  wire ilight_s;
  wire izero_s;
  wire load_light_s;
  wire lx_s;
  wire pok_pin_s;
  wire dd_pin_s;
  wire idd_pin_s;

  assign raw_in = {inv_drain_out_i, direct_drain_out_i, power_ok_out_i, switch_node,
    load_light_in, cur_zero_in, cur_light_in, cur_limit_in, fb_below_third_in,
    fb_over_window_in, fb_under_window_in, fb_below_ref_in, blanking_select_in,
    voltage_sel_in, pwm_force_in, shutdown_n, 2'h0};

  bsm_sync #(
    .W(19)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(raw_in),
    .sync_out(syn)
  );

  assign idd_pin_s = syn[18];
  assign dd_pin_s = syn[17];
  assign pok_pin_s = syn[16];
  assign lx_s = syn[15];
  assign load_light_s = syn[14];
  assign izero_s = syn[13];
  assign ilight_s = syn[12];
  assign ilim_s = syn[11];
  assign fb_third_s = syn[10];
  assign win_over_s = syn[9];
  assign win_under_s = syn[8];
  assign fb_low_s = syn[7];
  assign bsel_s = syn[6:5];
  assign vsel_s = syn[4];
  assign fpwm_s = syn[3];
  assign sd_n_s = syn[2];

  // ==========================================================
  // Register bus slave
  reg ctrl_enable_ff;
  reg ctrl_fpwm_ff;
  reg [15:0] off_time_ff;
  reg dp_valid_ff;
  reg dp_write_ff;
  reg [7:0] dp_addr_ff;
  reg [31:0] rd_word;
  reg [4:0] state_ff;
  reg [9:0] ss_cnt_ff;
  reg ss_active_ff;
  reg ext_off_ff;
  reg vsel_d_ff;
  reg lx_d_ff;
  wire blank_busy;
  wire pwm_mode;
  wire ahb_take;

  assign ahb_take = hsel & htrans[1] & hready;

  always @*
  begin
    rd_word = 32'h0;
    case (haddr)
      `BSM_OFF_CTRL: rd_word = {30'h0, ctrl_fpwm_ff, ctrl_enable_ff};
      `BSM_OFF_OFFTIME: rd_word = {16'h0, off_time_ff};
      `BSM_OFF_STATUS: rd_word = {20'h0, vsel_s, idd_pin_s, dd_pin_s, pok_pin_s,
        blank_busy, ext_off_ff, ~pwm_mode, ss_active_ff, ilim_level_ff,
        low_side_on_ff, high_side_on_ff};
      `BSM_OFF_SSCOUNT: rd_word = {22'h0, ss_cnt_ff};
      default: rd_word = 32'h0;
    endcase
  end

  // Zero wait states; read data is latched at the address phase so
  // hrdata comes straight from a flop during the data phase.
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      dp_valid_ff <= 1'b0;
      dp_write_ff <= 1'b0;
      dp_addr_ff <= 8'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl_enable_ff <= `BSM_CTRL_ENABLE_RST;
      ctrl_fpwm_ff <= `BSM_CTRL_FPWM_RST;
      off_time_ff <= `BSM_OFFTIME_RST;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_valid_ff <= ahb_take;
      if (ahb_take)
      begin
        dp_write_ff <= hwrite;
        dp_addr_ff <= haddr;
        hrdata <= hwrite ? 32'h0 : rd_word;
      end
      if (dp_valid_ff && dp_write_ff)
      begin
        case (dp_addr_ff)
          `BSM_OFF_CTRL:
          begin
            ctrl_enable_ff <= hwdata[`BSM_CTRL_ENABLE_BIT];
            ctrl_fpwm_ff <= hwdata[`BSM_CTRL_FPWM_BIT];
          end
          `BSM_OFF_OFFTIME: off_time_ff <= hwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Blanking after a voltage-select change
  wire run_en;
  wire vsel_edge;
  wire [15:0] blank_len;

  assign run_en = sd_n_s & ctrl_enable_ff;
  assign vsel_edge = vsel_s ^ vsel_d_ff;
  assign blank_len = blank_cycles(bsel_s);

  bsm_cycle_timer #(
    .W(16)
  ) u_blank (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .load(vsel_edge),
    .load_val(blank_len),
    .busy(blank_busy)
  );

  // ==========================================================
  // Mode selection
  // Overload runs like forced PWM, so extended off-time takes that path.
  assign pwm_mode = fpwm_s | ctrl_fpwm_ff | blank_busy | ext_off_ff
    | ~load_light_s;

  // ==========================================================
  // Soft-start and extended off-time
  wire lx_rise;
  wire ss_done;

  assign lx_rise = lx_s & ~lx_d_ff;
  assign ss_done = (ss_cnt_ff == `BSM_SS_END_CNT) | ~fb_low_s;

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      vsel_d_ff <= 1'b0;
      lx_d_ff <= 1'b0;
      ss_cnt_ff <= 10'h0;
      ss_active_ff <= 1'b1;
      ilim_level_ff <= 2'h0;
      ext_off_ff <= 1'b0;
    end
    else
    begin
      vsel_d_ff <= vsel_s;
      lx_d_ff <= lx_s;
      if (!run_en)
      begin
        ss_cnt_ff <= 10'h0;
        ss_active_ff <= 1'b1;
        ilim_level_ff <= 2'h0;
        ext_off_ff <= 1'b0;
      end
      else
      begin
        if (ss_active_ff)
        begin
          if (ss_done)
          begin
            ss_active_ff <= 1'b0;
            ilim_level_ff <= 2'h3;
          end
          else
          begin
            if (lx_rise)
              ss_cnt_ff <= ss_cnt_ff + 10'h1;
            ilim_level_ff <= ss_cnt_ff[9:8];
          end
        end
        if (fb_third_s)
          ext_off_ff <= 1'b1;
        else if (!ilim_s)
          ext_off_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Switch sequencing
  reg [4:0] nxt_state;
  reg off_load;
  wire off_busy;
  wire [17:0] off_len;

  assign off_len = ext_off_ff ? {off_time_ff, `BSM_EXT_SHIFT'h0}
    : {`BSM_EXT_SHIFT'h0, off_time_ff};

  bsm_cycle_timer #(
    .W(18)
  ) u_off (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .load(off_load),
    .load_val(off_len),
    .busy(off_busy)
  );

  always @*
  begin
    nxt_state = state_ff;
    off_load = 1'b0;
    case (state_ff)
      ST_IDLE:
        nxt_state = ST_HS;
      ST_HS:
      begin
        // Held on while below regulation and under the limit; in skip mode also held until light current.
        if (pwm_mode)
        begin
          if (!fb_low_s || ilim_s)
          begin
            nxt_state = ST_LS;
            off_load = 1'b1;
          end
        end
        else if ((!fb_low_s && ilight_s) || ilim_s)
          nxt_state = ST_SKIP_LS;
      end
      ST_LS:
        if (!off_busy)
          nxt_state = ST_HS;
      ST_SKIP_LS:
        if (izero_s)
          nxt_state = ST_SKIP_WAIT;
      ST_SKIP_WAIT:
        if (pwm_mode || fb_low_s)
          nxt_state = ST_HS;
      default:
        nxt_state = ST_IDLE;
    endcase
    if (!run_en)
      nxt_state = ST_IDLE;
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_IDLE;
      high_side_on_ff <= 1'b0;
      low_side_on_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      high_side_on_ff <= (nxt_state == ST_HS);
      low_side_on_ff <= (nxt_state == ST_LS) || (nxt_state == ST_SKIP_LS);
    end
  end

  // ==========================================================
  // Open-drain outputs
  // Data lines stay low; the enable pulls the pin, release is high-Z.
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      power_ok_out_o <= 1'b0;
      power_ok_out_oe <= 1'b1;
      direct_drain_out_o <= 1'b0;
      direct_drain_out_oe <= 1'b0;
      inv_drain_out_o <= 1'b0;
      inv_drain_out_oe <= 1'b0;
    end
    else
    begin
      power_ok_out_o <= 1'b0;
      direct_drain_out_o <= 1'b0;
      inv_drain_out_o <= 1'b0;
      direct_drain_out_oe <= vsel_s;
      inv_drain_out_oe <= ~vsel_s;
      if (!run_en || ss_active_ff)
        power_ok_out_oe <= 1'b1;
      else if (blank_enabled(bsel_s) && blank_busy)
        power_ok_out_oe <= 1'b0;
      else
        power_ok_out_oe <= win_under_s | win_over_s;
    end
  end

endmodule

// ---- bsm_ctrl_checker.sv ----
/* Concurrent checks on the bsm_ctrl pins, attached by the bind below.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
// ==========================================
// Checker
module bsm_ctrl_checker (
  input wire ref_clk,
  input wire sys_rst,
  input wire shutdown_n,
  input wire voltage_sel_in,
  input wire high_side_on_ff,
  input wire low_side_on_ff,
  input wire [1:0] ilim_level_ff,
  input wire power_ok_out_o,
  input wire power_ok_out_oe,
  input wire direct_drain_out_oe,
  input wire inv_drain_out_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // Five samples span two sync flops plus the output flop
  property p_inv_drain;
    (!voltage_sel_in) [*5] |-> inv_drain_out_oe && !direct_drain_out_oe;
  endproperty
  a_inv_drain: assert property (p_inv_drain) else $error("inverted drain wrong");
  property p_dir_drain;
    voltage_sel_in [*5] |-> direct_drain_out_oe && !inv_drain_out_oe;
  endproperty
  a_dir_drain: assert property (p_dir_drain) else $error("direct drain wrong");
  property p_pok_level;
    !power_ok_out_o;
  endproperty
  a_pok_level: assert property (p_pok_level) else $error("power ok drives high");
  // Shutdown may take one extra state step
  property p_sd_switch;
    (!shutdown_n) [*6] |-> !high_side_on_ff && !low_side_on_ff;
  endproperty
  a_sd_switch: assert property (p_sd_switch) else $error("switch on in shutdown");
  property p_sd_pok;
    (!shutdown_n) [*6] |-> power_ok_out_oe;
  endproperty
  a_sd_pok: assert property (p_sd_pok) else $error("power ok released in shutdown");
  property p_sd_ilim;
    (!shutdown_n) [*6] |-> ilim_level_ff == 2'h0;
  endproperty
  a_sd_ilim: assert property (p_sd_ilim) else $error("limit not back to quarter");
  property p_excl;
    !(high_side_on_ff && low_side_on_ff);
  endproperty
  a_excl: assert property (p_excl) else $error("both switches on");
  property p_ilim_up;
    $changed(ilim_level_ff) && ilim_level_ff != 2'h0 |-> ilim_level_ff > $past(ilim_level_ff);
  endproperty
  a_ilim_up: assert property (p_ilim_up) else $error("limit stepped down");
  c_full: cover property (ilim_level_ff == 2'h3);
  c_pok: cover property ($fell(power_ok_out_oe));
  c_low: cover property ($rose(low_side_on_ff));
endmodule

bind bsm_ctrl bsm_ctrl_checker u_chk (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .shutdown_n(shutdown_n),
  .voltage_sel_in(voltage_sel_in),
  .high_side_on_ff(high_side_on_ff),
  .low_side_on_ff(low_side_on_ff),
  .ilim_level_ff(ilim_level_ff),
  .power_ok_out_o(power_ok_out_o),
  .power_ok_out_oe(power_ok_out_oe),
  .direct_drain_out_oe(direct_drain_out_oe),
  .inv_drain_out_oe(inv_drain_out_oe)
);

// ---- bsm_analog_model.sv ----
/* Power stage and current comparators seen from the controller.
   Assumes switch enables change only at rising clock edges. */
`timescale 1ns/1ps
// ==========================================
// Power stage model
module bsm_analog_model #(
  parameter int LIM_CYC = 4
) (
  input wire ref_clk,
  input wire hs_on,
  input wire ls_on,
  output logic switch_node = 1'b0,
  output logic cur_limit_in = 1'b0,
  output logic cur_light_in = 1'b0,
  output logic cur_zero_in = 1'b1
);
  int hs_cnt_ff = 0;
  int ls_cnt_ff = 0;
  logic last_ff = 1'b0;
  // Floating node shows the inverse of its last level, so each release makes an edge
  always @(posedge ref_clk)
  begin
    hs_cnt_ff <= hs_on ? hs_cnt_ff + 1 : 0;
    ls_cnt_ff <= ls_on ? ls_cnt_ff + 1 : 0;
    if (hs_on || ls_on)
      last_ff <= hs_on;
    switch_node <= (hs_on || ls_on) ? hs_on : !last_ff;
    cur_light_in <= hs_on && hs_cnt_ff >= 1;
    cur_limit_in <= hs_on && hs_cnt_ff >= LIM_CYC - 1;
    cur_zero_in <= !ls_on || ls_cnt_ff >= 2;
  end
endmodule

// ---- buck_switch_mode_control_tb.sv ----
/* Self-checking bench for bsm_ctrl with the power stage model.
   Assumes short blanking parameters and a zero-wait AHB-Lite slave. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
`define WAIT_FOR(c, lim) begin for (wn = 0; !(c) && wn < lim; wn++) @(negedge ref_clk); \
  if (!(c)) hang(); end
module buck_switch_mode_control_tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic shutdown_n = 1'b1;
  logic pwm_force = 1'b1;
  logic vsel = 1'b0;
  logic [1:0] bsel = 2'h0;
  logic below_ref = 1'b1;
  logic fb_under = 1'b0;
  logic fb_over = 1'b0;
  logic fb_third = 1'b0;
  logic light = 1'b0;
  logic [31:0] rd;
  int failures = 0;
  int total_checks = 0;
  int wn, cnt, hcnt, n;
  int blk [4] = '{0, 10, 20, 30};
  logic [72:0] rows [5] = '{{1'b0, 8'h00, 32'h0, 32'h1}, {1'b0, 8'h04, 32'h0, 32'h32},
    {1'b1, 8'h04, 32'h8, 32'h8}, {1'b1, 8'h10, 32'hffffffff, 32'h0},
    {1'b1, 8'h00, 32'h1, 32'h1}};
  wire [31:0] hrdata;
  wire hreadyout, hresp, hs, ls, sw, lim, cl, zero;
  wire [1:0] ilim;
  wire pok_o, pok_oe, dd_o, dd_oe, id_o, id_oe;
  wire pok_pin = pok_oe ? pok_o : 1'b1;
  wire dd_pin = dd_oe ? dd_o : 1'b1;
  wire id_pin = id_oe ? id_o : 1'b1;
  // ==========================================
  // Design and power stage
  bsm_ctrl #(.BLANK_LONG_CYC(16'd30), .BLANK_MID_CYC(16'd20), .BLANK_SHORT_CYC(16'd10)) DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .shutdown_n(shutdown_n), .pwm_force_in(pwm_force),
    .voltage_sel_in(vsel), .blanking_select_in(bsel), .fb_below_ref_in(below_ref),
    .fb_under_window_in(fb_under), .fb_over_window_in(fb_over), .fb_below_third_in(fb_third),
    .cur_limit_in(lim), .cur_light_in(cl), .cur_zero_in(zero), .load_light_in(light),
    .switch_node(sw), .high_side_on_ff(hs), .low_side_on_ff(ls), .ilim_level_ff(ilim),
    .power_ok_out_i(pok_pin), .power_ok_out_o(pok_o), .power_ok_out_oe(pok_oe),
    .direct_drain_out_i(dd_pin), .direct_drain_out_o(dd_o), .direct_drain_out_oe(dd_oe),
    .inv_drain_out_i(id_pin), .inv_drain_out_o(id_o), .inv_drain_out_oe(id_oe));
  bsm_analog_model #(.LIM_CYC(4)) u_stage (.ref_clk(ref_clk), .hs_on(hs), .ls_on(ls),
    .switch_node(sw), .cur_limit_in(lim), .cur_light_in(cl), .cur_zero_in(zero));
  initial forever #5 ref_clk = !ref_clk;
  // ==========================================
  // Tasks
  task stop_test;
    begin
      if (failures == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task hang;
    begin
      failures++;
      $display("BAD wait exp 1 got 0");
      stop_test();
    end
  endtask
  task rdy;
    begin
      @(posedge ref_clk);
      for (wn = 0; hreadyout !== 1'b1 && wn < 50; wn++)
        @(posedge ref_clk);
      if (wn == 50)
        hang();
    end
  endtask
  // Address phase held until ready, then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      rdy();
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      rd = hrdata;
      hsel <= 1'b0;
    end
  endtask
  task ls_len;
    begin
      `WAIT_FOR(!ls, 300)
      `WAIT_FOR(ls, 300)
      for (n = 0; ls === 1'b1 && n < 300; n++)
        @(negedge ref_clk);
    end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    `CHK("ilim", 2'h0, ilim)
    foreach (rows[i])
    begin
      bus(rows[i][72], rows[i][71:64], rows[i][63:32]);
      bus(1'b0, rows[i][71:64], 32'h0);
      `CHK("reg", rows[i][31:0], rd)
      `CHK("hresp", 1'b0, hresp)
      `CHK("ready", 1'b1, hreadyout)
    end
    `WAIT_FOR(ilim == 2'h1, 20000)
    `CHK("pok_ss", 1'b1, pok_oe)
    `WAIT_FOR(ilim == 2'h3, 40000)
    bus(1'b0, 8'h0c, 32'h0);
    `CHK("sscount", 32'h300, rd)
    repeat (6) @(posedge ref_clk);
    `CHK("pok_run", 1'b0, pok_oe)
    fb_over <= 1'b1;
    repeat (6) @(posedge ref_clk);
    `CHK("pok_over", 1'b1, pok_oe)
    fb_over <= 1'b0;
    ls_len();
    `CHK("offtime", 1'b1, n >= 8 && n <= 10)
    @(posedge ref_clk);
    fb_third <= 1'b1;
    ls_len();
    ls_len();
    `CHK("ext", 1'b1, n >= 32 && n <= 34)
    @(posedge ref_clk);
    fb_third <= 1'b0;
    ls_len();
    ls_len();
    `CHK("ext_end", 1'b1, n >= 8 && n <= 10)
    @(posedge ref_clk);
    pwm_force <= 1'b0;
    light <= 1'b1;
    below_ref <= 1'b0;
    repeat (60) @(posedge ref_clk);
    for (hcnt = 0, n = 0; n < 40; n++)
      @(negedge ref_clk) hcnt += hs;
    `CHK("skip_idle", 0, hcnt)
    bus(1'b0, 8'h08, 32'h0);
    `CHK("skip_mode", 1'b1, rd[5])
    @(posedge ref_clk);
    below_ref <= 1'b1;
    `WAIT_FOR(hs, 10)
    `CHK("skip_start", 1'b1, hs)
    @(posedge ref_clk);
    below_ref <= 1'b0;
    light <= 1'b0;
    repeat (40) @(posedge ref_clk);
    `WAIT_FOR(hs, 80)
    `CHK("auto_pwm", 1'b1, hs)
    @(posedge ref_clk);
    pwm_force <= 1'b1;
    light <= 1'b1;
    `WAIT_FOR(hs, 80)
    `CHK("forced", 1'b1, hs)
    @(posedge ref_clk);
    pwm_force <= 1'b0;
    fb_under <= 1'b1;
    repeat (60) @(posedge ref_clk);
    for (int c = 0; c < 4; c++)
    begin
      bsel <= c[1:0];
      @(posedge ref_clk);
      vsel <= !vsel;
      for (cnt = 0, hcnt = 0, n = 0; n < 60; n++)
        @(negedge ref_clk) begin cnt += !pok_oe; hcnt += hs; end
      `CHK("blank", 1'b1, cnt >= blk[c] && cnt <= blk[c] + 2 * (c > 0))
      `CHK("force", 1'b1, hcnt > 0)
      `CHK("direct", vsel, dd_oe)
      `CHK("invert", !vsel, id_oe)
      `CHK("od_data", 3'h0, {pok_o, dd_o, id_o})
      @(posedge ref_clk);
    end
    shutdown_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    `CHK("sd_sw", 2'h0, {hs, ls})
    `CHK("sd_pok", 1'b1, pok_oe)
    `CHK("sd_ilim", 2'h0, ilim)
    @(posedge ref_clk);
    shutdown_n <= 1'b1;
    below_ref <= 1'b1;
    `WAIT_FOR(hs, 20)
    `CHK("restart", 2'h0, ilim)
    stop_test();
  end
endmodule
